// ==== rtl/msad_regs.vh ====
// Address map constants for the memory space address decoder
`ifndef MSAD_REGS_VH
`define MSAD_REGS_VH
`define MSAD_BOOT_LO 16'h0000
`define MSAD_BOOT_HI 16'h00FF
`define MSAD_PFLASH_LO 16'h0000
`define MSAD_PFLASH_HI 16'h7FFF
`define MSAD_PB0_LO 16'hFE00
`define MSAD_PB0_HI 16'hFFFF
`define MSAD_DB0_LO 16'h0100
`define MSAD_DB0_HI 16'h02FF
`define MSAD_DB1_LO 16'h0300
`define MSAD_DB1_HI 16'h04FF
`define MSAD_BLK_MASK 8'hFF
`define MSAD_OFF_MSB 7
`define MSAD_OFF_RST 8'h00
`define MSAD_OE_RST 1'b0
`define MSAD_BLK_LAST 255
`define MSAD_SEL_NONE 6'h00
`define MSAD_SEL_BOOT 6'h01
`define MSAD_SEL_FLASH 6'h02
`define MSAD_SEL_EXT 6'h04
`define MSAD_SEL_B0 6'h08
`define MSAD_SEL_B1 6'h10
`endif

// ==== rtl/msad_range.v ====
// Address range check used by the decoder
`timescale 1ns/1ps
`default_nettype none
module msad_range #(
  parameter [15:0] LO = 16'h0000,
  parameter [15:0] HI = 16'hFFFF
) (
  // Address in
  input wire [15:0] addr,
  // Hit out
  output wire hit
);
  assign hit = (addr >= LO) && (addr <= HI);
endmodule
`default_nettype wire

// ==== rtl/msad_decoder.v ====
// Program and data space address decoder with external data bus drive
//
// Function
// - Lower program space 0000-7FFF goes to on-chip flash when the source select is 0, else external.
// - With boot ROM enabled, program words 0000-00FF decode to the boot ROM.
// - With block-zero select at 1, program FE00-FEFF and FF00-FFFF both reach block zero.
// - With block-zero select at 0, data 0100-01FF and 0200-02FF both reach block zero.
// - Data 0300-03FF and 0400-04FF always reach block one.
// - External data is a 16-bit two-way bus whose lines read high when undriven.
`timescale 1ns/1ps
`default_nettype none
`include "msad_regs.vh"
module msad_decoder #(
  parameter DW = 16
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Configuration
  input wire program_source_select,
  input wire block_zero_space_select,
  input wire boot_rom_enable,
  // CPU program bus
  input wire prog_req,
  input wire [15:0] prog_addr,
  // CPU data bus
  input wire data_req,
  input wire data_we,
  input wire [15:0] data_addr,
  input wire [DW-1:0] data_wdata,
  output reg [DW-1:0] data_rdata,
  // Program decode outputs
  output reg [5:0] prog_sel_r,
  output reg [7:0] prog_blk_off_r,
  // Data decode outputs
  output reg [5:0] data_sel_r,
  output reg [7:0] data_blk_off_r,
  // External data bus
  input wire [DW-1:0] ext_data_in,
  output reg [DW-1:0] ext_data_out,
  output reg ext_data_oe
);
  ////////////////////////////////////////////////////////////////
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Offset of an address within a block
  function [`MSAD_OFF_MSB:0] blk_off;
    input [15:0] addr;
    begin
      blk_off = addr[`MSAD_OFF_MSB:0] & `MSAD_BLK_MASK;
    end
  endfunction
  // One-hot select compare
  function sel_is;
    input [5:0] sel;
    input [5:0] code;
    begin
      sel_is = (sel == code);
    end
  endfunction
  ////////////////////////////////////////////////////////////////
  // Region hits
  wire p_boot;
  wire p_flash;
  wire p_b0;
  wire d_b0;
  wire d_b1;
  msad_range #(
    .LO(`MSAD_BOOT_LO),
    .HI(`MSAD_BOOT_HI)
  ) u_pboot (
    .addr(prog_addr),
    .hit(p_boot)
  );
  msad_range #(
    .LO(`MSAD_PFLASH_LO),
    .HI(`MSAD_PFLASH_HI)
  ) u_pfl (
    .addr(prog_addr),
    .hit(p_flash)
  );
  msad_range #(
    .LO(`MSAD_PB0_LO),
    .HI(`MSAD_PB0_HI)
  ) u_pb0 (
    .addr(prog_addr),
    .hit(p_b0)
  );
  msad_range #(
    .LO(`MSAD_DB0_LO),
    .HI(`MSAD_DB0_HI)
  ) u_db0 (
    .addr(data_addr),
    .hit(d_b0)
  );
  msad_range #(
    .LO(`MSAD_DB1_LO),
    .HI(`MSAD_DB1_HI)
  ) u_db1 (
    .addr(data_addr),
    .hit(d_b1)
  );
  ////////////////////////////////////////////////////////////////
  // Priority: boot, then block zero, then flash, else external
  reg [5:0] prog_sel_nxt;
  reg [5:0] data_sel_nxt;
  always @*
  begin
    prog_sel_nxt = `MSAD_SEL_NONE;
    if (prog_req)
    begin
      if (boot_rom_enable && p_boot)
        prog_sel_nxt = `MSAD_SEL_BOOT;
      else if (block_zero_space_select && p_b0)
        prog_sel_nxt = `MSAD_SEL_B0;
      else if (p_flash && !program_source_select)
        prog_sel_nxt = `MSAD_SEL_FLASH;
      else
        prog_sel_nxt = `MSAD_SEL_EXT;
    end
    data_sel_nxt = `MSAD_SEL_NONE;
    if (data_req)
    begin
      if (!block_zero_space_select && d_b0)
        data_sel_nxt = `MSAD_SEL_B0;
      else if (d_b1)
        data_sel_nxt = `MSAD_SEL_B1;
      else
        data_sel_nxt = `MSAD_SEL_EXT;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Offsets and write strobes
  wire [`MSAD_OFF_MSB:0] d_off;
  wire [`MSAD_OFF_MSB:0] p_off;
  wire wr_b0;
  wire wr_b1;
  wire ext_wr_nxt;
  assign d_off = blk_off(data_addr);
  assign p_off = blk_off(prog_addr);
  assign wr_b0 = data_we && sel_is(data_sel_nxt, `MSAD_SEL_B0);
  assign wr_b1 = data_we && sel_is(data_sel_nxt, `MSAD_SEL_B1);
  assign ext_wr_nxt = data_we && sel_is(data_sel_nxt, `MSAD_SEL_EXT);
  ////////////////////////////////////////////////////////////////
  // Block storage, both aliases index one array
  reg [DW-1:0] dual_access_block_zero [0:`MSAD_BLK_LAST];
  reg [DW-1:0] dual_access_block_one [0:`MSAD_BLK_LAST];
  always @(posedge clock)
  begin
    if (wr_b0)
      dual_access_block_zero[d_off] <= data_wdata;
    if (wr_b1)
      dual_access_block_one[d_off] <= data_wdata;
  end
  ////////////////////////////////////////////////////////////////
  // Program decode outputs
  always @(posedge clock or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      prog_sel_r <= `MSAD_SEL_NONE;
      prog_blk_off_r <= `MSAD_OFF_RST;
    end
    else
    begin
      prog_sel_r <= prog_sel_nxt;
      prog_blk_off_r <= p_off;
    end
  end
  // Data decode outputs
  always @(posedge clock or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      data_sel_r <= `MSAD_SEL_NONE;
      data_blk_off_r <= `MSAD_OFF_RST;
    end
    else
    begin
      data_sel_r <= data_sel_nxt;
      data_blk_off_r <= d_off;
    end
  end
  // Read data, held across writes
  always @(posedge clock or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
      data_rdata <= {DW{1'b0}};
    else if (!data_we)
    begin
      case (data_sel_nxt)
        `MSAD_SEL_B0:
          data_rdata <= dual_access_block_zero[d_off];
        `MSAD_SEL_B1:
          data_rdata <= dual_access_block_one[d_off];
        `MSAD_SEL_EXT:
          data_rdata <= ext_data_in;
        default:
          data_rdata <= {DW{1'b0}};
      endcase
    end
  end
  // External bus drive, one cycle per external write
  always @(posedge clock or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      ext_data_out <= {DW{1'b0}};
      ext_data_oe <= `MSAD_OE_RST;
    end
    else
    begin
      ext_data_out <= data_wdata;
      ext_data_oe <= ext_wr_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== dv/msad_ext_bus.sv ====
// External data bus with line pull-ups
`timescale 1ns/1ps
`default_nettype none
module msad_ext_bus (
  // Drive side
  input wire logic oe,
  input wire logic [15:0] dout,
  // Bus level
  output logic [15:0] din
);
  assign din = oe ? dout : 16'hFFFF;
endmodule
`default_nettype wire

// ==== dv/msad_asserts.sv ====
// Decoder port checks
`timescale 1ns/1ps
`default_nettype none
module msad_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Configuration
  input wire logic program_source_select,
  input wire logic block_zero_space_select,
  input wire logic boot_rom_enable,
  // CPU buses
  input wire logic prog_req,
  input wire logic [15:0] prog_addr,
  input wire logic data_req,
  input wire logic data_we,
  input wire logic [15:0] data_addr,
  input wire logic [15:0] data_wdata,
  // Decode and external bus outputs
  input wire logic [5:0] prog_sel_r,
  input wire logic [5:0] data_sel_r,
  input wire logic ext_data_oe,
  input wire logic [15:0] ext_data_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_fl; prog_req && prog_addr inside {[16'h0100:16'h7FFF]} &&
    !program_source_select |=> prog_sel_r == 6'h02; endproperty
  a_fl: assert property (p_fl) else $error("flash select");
  property p_bt; prog_req && boot_rom_enable && prog_addr[15:8] == 8'h00
    |=> prog_sel_r == 6'h01; endproperty
  a_bt: assert property (p_bt) else $error("boot select");
  property p_pb; prog_req && block_zero_space_select && prog_addr[15:9] == 7'h7F
    |=> prog_sel_r == 6'h08; endproperty
  a_pb: assert property (p_pb) else $error("program block zero");
  property p_db; data_req && !block_zero_space_select &&
    data_addr inside {[16'h0100:16'h02FF]} |=> data_sel_r == 6'h08; endproperty
  a_db: assert property (p_db) else $error("data block zero");
  property p_b1; data_req && data_addr inside {[16'h0300:16'h04FF]}
    |=> data_sel_r == 6'h10; endproperty
  a_b1: assert property (p_b1) else $error("block one");
  property p_xw; data_req && data_we && data_addr[15]
    |=> ext_data_oe && ext_data_out == $past(data_wdata); endproperty
  a_xw: assert property (p_xw) else $error("external write");
  property p_xi; !(data_req && data_we) |=> !ext_data_oe; endproperty
  a_xi: assert property (p_xi) else $error("external bus driven without write");
  c_bt: cover property (prog_req && boot_rom_enable && prog_addr[15:8] == 8'h00);
  c_xw: cover property (ext_data_oe);
  c_b1: cover property (data_req && data_sel_r == 6'h10);
  c_db: cover property (data_req && data_sel_r == 6'h08);
endmodule
bind msad_decoder msad_asserts u_chk (.*);
`default_nettype wire

// ==== dv/memory_space_address_decoder_tb_top.sv ====
// Random decode test of the address decoder
`timescale 1ns/1ps
`default_nettype none
module memory_space_address_decoder_tb_top;
  logic clock = 0, rst_n = 0, ps = 0, bz = 0, br = 0, pr = 0, dr = 0, we = 0, oe;
  logic [15:0] pa = 0, da = 0, wd = 0, rd, xo, xi;
  logic [5:0] psel, dsel;
  logic [7:0] po, dof;
  int fail_count, n_compared, cyc, k, i;
  logic pxw = 0;
  logic [15:0] pwd = 0;
  logic [15:0] m[int];
  msad_decoder u_dut (.clock(clock), .rst_n(rst_n), .program_source_select(ps),
    .block_zero_space_select(bz), .boot_rom_enable(br), .prog_req(pr), .prog_addr(pa),
    .data_req(dr), .data_we(we), .data_addr(da), .data_wdata(wd), .data_rdata(rd),
    .prog_sel_r(psel), .prog_blk_off_r(po), .data_sel_r(dsel), .data_blk_off_r(dof),
    .ext_data_in(xi), .ext_data_out(xo), .ext_data_oe(oe));
  msad_ext_bus u_ext (.oe(oe), .dout(xo), .din(xi));
  always #4 clock = ~clock;
  function [5:0] psf(input [15:0] a);
    psf = br && a < 16'h0100 ? 6'h01 : bz && a >= 16'hFE00 ? 6'h08 :
      !ps && a < 16'h8000 ? 6'h02 : 6'h04;
  endfunction
  function [5:0] dsf(input [15:0] a);
    dsf = !bz && a >= 16'h0100 && a < 16'h0300 ? 6'h08 :
      a >= 16'h0300 && a < 16'h0500 ? 6'h10 : 6'h04;
  endfunction
  task chk(input [16:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clock)
    if (++cyc > 3000)
    begin
      fail_count++;
      close_out;
    end
  initial
  begin
    void'($urandom(22));
    repeat (20) @(negedge clock);
    chk({psel, dsel, oe}, 17'h00000);
    chk(rd, 17'h00000);
    rst_n = 1;
    repeat (3) @(negedge clock);
    for (i = 0; i < 2012; i++)
    begin
      k = {dsf(da), da[7:0]};
      chk({psel, po}, {pr ? psf(pa) : 6'h00, pa[7:0]});
      chk({dsel, dof}, {dr ? dsf(da) : 6'h00, da[7:0]});
      if (dr && !we) chk(rd, dsf(da) == 6'h04 ? (pxw ? pwd : 16'hFFFF) : m[k]);
      chk(oe, dr && we && dsf(da) == 6'h04);
      if (dr && we && dsf(da) == 6'h04) chk({oe, xo}, {1'b1, wd});
      if (dr && we && dsf(da) != 6'h04) m[k] = wd;
      pxw = dr && we && dsf(da) == 6'h04;
      pwd = wd;
      {ps, bz, br, pr, dr, we} = 6'($urandom);
      pa = 16'($urandom);
      if (pa[14]) pa = {{7{pa[15]}}, pa[8:0]};
      da = 16'($urandom % 1024) + 16'h0100;
      da[15] = $urandom % 4 == 0;
      wd = 16'($urandom);
      if (i < 512)
      begin
        {bz, dr, we} = 3'b011;
        da = 16'h0100 + 16'(i) + (i >= 256 ? 16'h0100 : 16'h0000);
      end
      @(negedge clock);
    end
    close_out;
  end
endmodule
`default_nettype wire
